// >>> src/sbsm_spi_safety.sv
// SPI slave, frame checking and mode control of a system basis chip.
// Assumes the host is SPI master; pins are asynchronous to clk.
//
// Overview of operation
// - Invalid address or rw code writes nothing
// - Mode changes only when both registers match
// - Parity bits are pairwise XORs of data
// - Write only if computed parity matches received
// - Bad frame discarded, error flag readable
// - Exchange only while chip select low
// - Commit write at chip select rising edge
// - Output driver enabled while chip select low
// - Deselected: ignore clock and data, tristate
// - Sample input on falling clock edge
// - Update output on rising clock edge
// - Sixteen-bit frame, bit 15 first
// - Output shifts MSB first alongside input
// - Mode register reads return mode status
// - Reset clears mode registers, post-reset mode
// - Mode codes normal standby sleep emergency
// - Switch on bit gated by mode, sense bits
// - Cyclic bit enables sensing; linked bit resets 1
// - Address map decode, undefined addresses invalid
// - Frame: address, rw, parity, data fields
// - Bad full-length frame raises interrupt, state kept
// - Read returns old header, then new data
`include "sbsm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sbsm_spi_safety
  import sbsm_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            chipSelectN,
  input  wire logic            serialClock,
  input  wire logic            serialIn,
  input  wire logic            resetInN,
  output var  logic            serialOut,
  output var  logic            serialOutEn,
  output var  logic [2:0]      modeStatus,
  output var  logic            highSideSwitchOn,
  output var  logic            cyclicSenseOn,
  output var  logic            forcedWakeOn,
  output var  logic            wakeInputsLinked,
  output var  logic            frameErrorIrq,
  output var  sbsm_pkg::sbsm_frame_t lastFrame
);
  import sbsm_pkg::*;

  // Full-address lookup; single-bit flips land on undefined codes, except 6'h25, one flip from 6'h05, 6'h21 and 6'h24
  // A plain list keeps the map easy to audit against the address table
  function automatic logic addrValid(input logic [5:0] a);
    case (a)
      `SBSM_ADDR_MODE_CONTROL,
      `SBSM_ADDR_MODE_VALIDATION,
      `SBSM_ADDR_SWITCH_CONTROL,
      `SBSM_ADDR_CYCLIC_TIMING,
      `SBSM_ADDR_WATCHDOG,
      `SBSM_ADDR_GROUND_SHIFT,
      `SBSM_ADDR_WAKE_CONTROL,
      `SBSM_ADDR_WAKE_STATUS,
      `SBSM_ADDR_WAKE_LIVE,
      `SBSM_ADDR_OVERTEMP,
      `SBSM_ADDR_BUS_HIGH_ERR,
      `SBSM_ADDR_BUS_LOW_ERR,
      `SBSM_ADDR_RESET_SOURCE,
      `SBSM_ADDR_SUPPLY_STATUS,
      `SBSM_ADDR_INT_MASK_FIRST,
      `SBSM_ADDR_INT_MASK_SECOND,
      `SBSM_ADDR_INT_SRC_FIRST,
      `SBSM_ADDR_INT_SRC_SECOND,
      `SBSM_ADDR_TRANSCEIVER,
      `SBSM_ADDR_ERROR_FLAG:
      begin
        addrValid = 1'b1;
      end
      default:
      begin
        addrValid = 1'b0;
      end
    endcase
  endfunction

  function automatic logic [3:0] parityOf(input logic [3:0] d);
    parityOf = {d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0]};
  endfunction

  function automatic logic modeCodeValid(input logic [2:0] m);
    modeCodeValid = (m == SBSM_NORMAL) || (m == SBSM_STANDBY) ||
                    (m == SBSM_SLEEP) || (m == SBSM_EMERGENCY);
  endfunction

  // Pin synchronisers
  logic [1:0] csSync_reg;
  logic [1:0] sclkSync_reg;
  logic [1:0] mosiSync_reg;
  logic [1:0] rstSync_reg;
  logic       csPrev_reg;
  logic       sclkPrev_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      csSync_reg   <= 2'h3;
      sclkSync_reg <= 2'h0;
      mosiSync_reg <= 2'h0;
      rstSync_reg  <= 2'h3;
      csPrev_reg   <= 1'b1;
      sclkPrev_reg <= 1'b0;
    end
    else
    begin
      csSync_reg   <= {csSync_reg[0], chipSelectN};
      sclkSync_reg <= {sclkSync_reg[0], serialClock};
      mosiSync_reg <= {mosiSync_reg[0], serialIn};
      rstSync_reg  <= {rstSync_reg[0], resetInN};
      csPrev_reg   <= csSync_reg[1];
      sclkPrev_reg <= sclkSync_reg[1];
    end
  end

  logic selected;
  logic csRise;
  logic csFall;
  logic sclkRise;
  logic sclkFall;
  logic chipResetN;
  assign selected   = ~csSync_reg[1];
  assign csRise     = csSync_reg[1] & ~csPrev_reg;
  assign csFall     = ~csSync_reg[1] & csPrev_reg;
  assign sclkRise   = selected & sclkSync_reg[1] & ~sclkPrev_reg;
  assign sclkFall   = selected & ~sclkSync_reg[1] & sclkPrev_reg;
  assign chipResetN = rstSync_reg[1];

  // Shift path
  sbsm_frame_t inShift_reg;
  sbsm_frame_t outShift_reg;
  logic [4:0]  bitCount_reg;
  sbsm_frame_t prevFrame_reg;
  logic [3:0]  modeReadback;
  logic [3:0]  readData;
  logic [3:0]  readParity;
  logic [3:0]  switchBits_reg;
  logic        errorFlag_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      inShift_reg  <= 16'h0000;
      bitCount_reg <= 5'h00;
    end
    else if (csFall)
    begin
      bitCount_reg <= 5'h00;
    end
    // Counting one past a full frame marks over-long frames so they are not committed
    else if (sclkFall && bitCount_reg != (`SBSM_FRAME_BITS + 5'h01))
    begin
      inShift_reg  <= {inShift_reg[14:0], mosiSync_reg[1]};
      bitCount_reg <= bitCount_reg + 5'h01;
    end
  end

  // Read data is picked from the header as soon as the eighth bit is in
  always_comb
  begin
    case (inShift_reg[7:2])
      `SBSM_ADDR_MODE_CONTROL, `SBSM_ADDR_MODE_VALIDATION: readData = modeReadback;
      `SBSM_ADDR_SWITCH_CONTROL: readData = {wakeInputsLinked, forcedWakeOn,
                                             cyclicSenseOn, switchBits_reg[0]};
      `SBSM_ADDR_ERROR_FLAG:     readData = {3'h0, errorFlag_reg};
      default:                   readData = 4'h0;
    endcase
  end

  // Host checks returned data with the same parity it sends
  assign readParity = parityOf(readData);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      outShift_reg <= 16'h0000;
    end
    else if (csFall)
    begin
      outShift_reg <= prevFrame_reg;
    end
    else if (sclkRise && bitCount_reg == 5'h08)
    begin
      outShift_reg <= {readParity, readData, 8'h00};
    end
    else if (sclkRise && bitCount_reg != 5'h00)
    begin
      outShift_reg <= {outShift_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      serialOut   <= 1'b0;
      serialOutEn <= 1'b0;
    end
    else
    begin
      serialOutEn <= selected;
      if (csFall)
      begin
        serialOut <= prevFrame_reg[15];
      end
      else if (sclkRise && bitCount_reg == 5'h08)
      begin
        serialOut <= readParity[3];
      end
      else if (sclkRise && bitCount_reg != 5'h00)
      begin
        serialOut <= outShift_reg[14];
      end
    end
  end

  // Frame commit at deselect; only a full frame is considered
  logic        frameDone;
  logic [5:0]  fAddr;
  logic [1:0]  fRw;
  logic [3:0]  fPar;
  logic [3:0]  fData;
  logic        frameGood;
  logic        writeOk;
  assign frameDone = csRise && bitCount_reg == `SBSM_FRAME_BITS;
  assign fAddr     = inShift_reg[15:10];
  assign fRw       = inShift_reg[9:8];
  assign fPar      = inShift_reg[7:4];
  assign fData     = inShift_reg[3:0];
  assign frameGood = addrValid(fAddr) && (fRw == `SBSM_RW_WRITE || fRw == `SBSM_RW_READ) &&
                     parityOf(fData) == fPar;
  assign writeOk   = frameDone && frameGood && fRw == `SBSM_RW_WRITE;

  logic [2:0] modeCtrl_reg;
  logic [2:0] modeValid_reg;
  logic [2:0] mode_reg;
  assign modeReadback = {1'b0, mode_reg};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prevFrame_reg <= 16'h0000;
    end
    else if (frameDone)
    begin
      prevFrame_reg <= inShift_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || !chipResetN)
    begin
      modeCtrl_reg  <= `SBSM_MODE_RESET;
      modeValid_reg <= `SBSM_MODE_RESET;
      mode_reg      <= SBSM_POST_RESET;
    end
    else
    begin
      if (writeOk && fAddr == `SBSM_ADDR_MODE_CONTROL)
      begin
        modeCtrl_reg <= fData[2:0];
      end
      if (writeOk && fAddr == `SBSM_ADDR_MODE_VALIDATION)
      begin
        modeValid_reg <= fData[2:0];
        // Ordered pair: validation write confirms the earlier control write
        if (fData[2:0] == modeCtrl_reg && modeCodeValid(fData[2:0]))
        begin
          mode_reg <= fData[2:0];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || !chipResetN)
    begin
      switchBits_reg <= `SBSM_SWITCH_RESET;
    end
    else if (writeOk && fAddr == `SBSM_ADDR_SWITCH_CONTROL)
    begin
      switchBits_reg <= fData;
    end
  end

  // Error flag is sticky until read back; a new error wins over that read
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      errorFlag_reg <= 1'b0;
      frameErrorIrq <= 1'b0;
    end
    else
    begin
      frameErrorIrq <= frameDone && !frameGood;
      if (frameDone && !frameGood)
      begin
        errorFlag_reg <= 1'b1;
      end
      else if (frameDone && fRw == `SBSM_RW_READ && fAddr == `SBSM_ADDR_ERROR_FLAG)
      begin
        errorFlag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      modeStatus       <= 3'h0;
      highSideSwitchOn <= 1'b0;
      cyclicSenseOn    <= 1'b0;
      forcedWakeOn     <= 1'b0;
      wakeInputsLinked <= 1'b1;
      lastFrame        <= 16'h0000;
    end
    else
    begin
      modeStatus       <= mode_reg;
      highSideSwitchOn <= switchBits_reg[`SBSM_SW_ON_BIT] &&
                          !switchBits_reg[`SBSM_SW_CYCLIC_BIT] &&
                          !switchBits_reg[`SBSM_SW_FORCED_BIT] &&
                          (mode_reg == SBSM_NORMAL || mode_reg == SBSM_STANDBY);
      cyclicSenseOn    <= switchBits_reg[`SBSM_SW_CYCLIC_BIT];
      forcedWakeOn     <= switchBits_reg[`SBSM_SW_FORCED_BIT];
      wakeInputsLinked <= switchBits_reg[`SBSM_SW_LINKED_BIT];
      // Only checked frames are exposed, so a corrupted one never looks committed
      if (frameDone && frameGood)
      begin
        lastFrame <= inShift_reg;
      end
    end
  end
endmodule
`default_nettype wire

// >>> shared/sbsm_consts.svh
// Constants for the safety SPI mode control block.
// Assumes inclusion by bare name from the design and bench files.
`ifndef SBSM_CONSTS_SVH
`define SBSM_CONSTS_SVH
`define SBSM_ADDR_MODE_CONTROL      6'h00
`define SBSM_ADDR_MODE_VALIDATION   6'h03
`define SBSM_ADDR_SWITCH_CONTROL    6'h05
`define SBSM_ADDR_CYCLIC_TIMING     6'h06
`define SBSM_ADDR_WATCHDOG          6'h09
`define SBSM_ADDR_GROUND_SHIFT      6'h0A
`define SBSM_ADDR_WAKE_CONTROL      6'h0C
`define SBSM_ADDR_WAKE_STATUS       6'h0F
`define SBSM_ADDR_WAKE_LIVE         6'h11
`define SBSM_ADDR_OVERTEMP          6'h12
`define SBSM_ADDR_BUS_HIGH_ERR      6'h14
`define SBSM_ADDR_BUS_LOW_ERR       6'h17
`define SBSM_ADDR_RESET_SOURCE      6'h18
`define SBSM_ADDR_SUPPLY_STATUS     6'h1B
`define SBSM_ADDR_INT_MASK_FIRST    6'h1D
`define SBSM_ADDR_INT_MASK_SECOND   6'h1E
`define SBSM_ADDR_INT_SRC_FIRST     6'h21
`define SBSM_ADDR_INT_SRC_SECOND    6'h22
`define SBSM_ADDR_TRANSCEIVER       6'h24
`define SBSM_ADDR_ERROR_FLAG        6'h25
`define SBSM_RW_WRITE               2'h3
`define SBSM_RW_READ                2'h0
`define SBSM_FRAME_BITS             5'h10
`define SBSM_MODE_RESET             3'h0
`define SBSM_SWITCH_RESET           4'h8
`define SBSM_SW_ON_BIT              0
`define SBSM_SW_CYCLIC_BIT          1
`define SBSM_SW_FORCED_BIT          2
`define SBSM_SW_LINKED_BIT          3
`endif

// >>> shared/sbsm_pkg.sv
// Types for the safety SPI mode control block.
// Assumes sbsm_consts.svh is on the include path.
package sbsm_pkg;
  typedef enum logic [2:0] {
    SBSM_POST_RESET = 3'b000,
    SBSM_NORMAL     = 3'b001,
    SBSM_STANDBY    = 3'b010,
    SBSM_SLEEP      = 3'b100,
    SBSM_EMERGENCY  = 3'b111
  } sbsm_mode_e;
  typedef logic [15:0] sbsm_frame_t;
endpackage

// >>> bench/sbsm_spi_safety_checker.sv
// Assertions on the ports of the safety SPI mode control block.
// Assumes it is bound to sbsm_spi_safety and hosts keep 20 idle clocks between frames.
`timescale 1ns/1ps
`default_nettype none
module sbsm_spi_safety_checker
  import sbsm_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  chipSelectN,
  input wire logic                  serialClock,
  input wire logic                  serialIn,
  input wire logic                  resetInN,
  input wire logic                  serialOut,
  input wire logic                  serialOutEn,
  input wire logic [2:0]            modeStatus,
  input wire logic                  highSideSwitchOn,
  input wire logic                  cyclicSenseOn,
  input wire logic                  forcedWakeOn,
  input wire logic                  wakeInputsLinked,
  input wire logic                  frameErrorIrq,
  input wire sbsm_pkg::sbsm_frame_t lastFrame
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Six clocks covers the select synchroniser plus the output register
  sequence s_idle; chipSelectN [*6]; endsequence
  sequence s_busy; !chipSelectN [*8]; endsequence
  sequence s_pin_reset; !resetInN [*6]; endsequence
  property p_oe_off; s_idle |-> !serialOutEn; endproperty
  property p_oe_on; s_busy |-> serialOutEn; endproperty
  property p_mode_held; s_busy |-> $stable(modeStatus); endproperty
  property p_frame_held; s_busy |-> $stable(lastFrame); endproperty
  property p_irq_after_cs; frameErrorIrq |-> chipSelectN && $past(chipSelectN, 2); endproperty
  property p_irq_pulse; frameErrorIrq |=> !frameErrorIrq; endproperty
  property p_mode_code; modeStatus inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7}; endproperty
  property p_switch_gate;
    highSideSwitchOn |-> !cyclicSenseOn && !forcedWakeOn && modeStatus inside {3'h1, 3'h2};
  endproperty
  property p_pin_reset;
    s_pin_reset |-> modeStatus == 3'h0 && wakeInputsLinked && !forcedWakeOn;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driver on while idle");
  a_oe_on: assert property (p_oe_on) else $error("output driver off while selected");
  a_mode_held: assert property (p_mode_held) else $error("mode moved mid frame");
  a_frame_held: assert property (p_frame_held) else $error("frame moved mid frame");
  a_irq_after_cs: assert property (p_irq_after_cs) else $error("irq while selected");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one clock");
  a_mode_code: assert property (p_mode_code) else $error("illegal mode status");
  a_switch_gate: assert property (p_switch_gate) else $error("switch on when gated");
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied");
endmodule
bind sbsm_spi_safety sbsm_spi_safety_checker u_chk (.clk(clk), .reset(reset),
  .chipSelectN(chipSelectN), .serialClock(serialClock), .serialIn(serialIn),
  .resetInN(resetInN), .serialOut(serialOut), .serialOutEn(serialOutEn),
  .modeStatus(modeStatus), .highSideSwitchOn(highSideSwitchOn), .cyclicSenseOn(cyclicSenseOn),
  .forcedWakeOn(forcedWakeOn), .wakeInputsLinked(wakeInputsLinked),
  .frameErrorIrq(frameErrorIrq), .lastFrame(lastFrame));
`default_nettype wire

// >>> bench/sbsm_host_model.sv
// Host SPI master model with a 48 ns serial clock.
// Assumes clk is the block clock; frames start just after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module sbsm_host_model
  import sbsm_pkg::*;
(
  input  wire logic clk,
  input  wire logic serialOut,
  output var  logic chipSelectN,
  output var  logic serialClock,
  output var  logic serialIn
);
  initial
  begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    serialIn    = 1'b0;
  end
  task automatic xfer(input sbsm_frame_t tx, input int n, output sbsm_frame_t rx);
    rx = '0;
    @(posedge clk);
    #1 chipSelectN = 1'b0;
    #24;
    for (int i = 0; i < n; i++)
    begin
      serialClock = 1'b1;
      serialIn = tx[15 - i];
      #24 serialClock = 1'b0;
      rx[15 - i] = serialOut;
      #24;
    end
    // Inverted data so a stale bit is never mistaken for a held one
    serialIn = ~serialIn;
    #1 chipSelectN = 1'b1;
    repeat (20) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> bench/sbsm_spi_safety_test.sv
// Self-checking bench for the safety SPI mode control block.
// Assumes the host model and the bound checker are compiled alongside.
`include "sbsm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module sbsm_spi_safety_test;
  import sbsm_pkg::*;
  logic        clk, reset, resetInN, chipSelectN, serialClock, serialIn;
  logic        serialOut, serialOutEn, highSideSwitchOn, cyclicSenseOn;
  logic        forcedWakeOn, wakeInputsLinked, frameErrorIrq;
  logic [2:0]  modeStatus;
  sbsm_frame_t lastFrame, rxWord, prv, hdr;
  int          error_cnt, num_checks, irqCnt;
  sbsm_spi_safety DUT (.clk(clk), .reset(reset), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialIn(serialIn), .resetInN(resetInN),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .modeStatus(modeStatus),
    .highSideSwitchOn(highSideSwitchOn), .cyclicSenseOn(cyclicSenseOn),
    .forcedWakeOn(forcedWakeOn), .wakeInputsLinked(wakeInputsLinked),
    .frameErrorIrq(frameErrorIrq), .lastFrame(lastFrame));
  sbsm_host_model HOST (.clk(clk), .serialOut(serialOut), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialIn(serialIn));
  always #2.5 clk = ~clk;
  always @(posedge clk) if (frameErrorIrq === 1'b1) irqCnt <= irqCnt + 1;
  function automatic sbsm_frame_t fr(logic [5:0] a, logic [1:0] rw, logic [3:0] d);
    fr = {a, rw, d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0], d};
  endfunction
  task automatic go(input sbsm_frame_t f, input bit good, input int n = 16);
    HOST.xfer(f, n, rxWord);
    if (good) prv = f;
    if (n == 16) hdr = f;
    `CHK("last frame", prv, lastFrame)
  endtask
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    go(fr(a, `SBSM_RW_WRITE, d), 1'b1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [3:0] d, input string nm);
    sbsm_frame_t e;
    sbsm_frame_t p;
    e = fr(a, `SBSM_RW_READ, d);
    p = hdr;
    go(fr(a, `SBSM_RW_READ, 4'h0), 1'b1);
    `CHK("old header", p[15:8], rxWord[15:8])
    `CHK(nm, e[7:0], rxWord[7:0])
  endtask
  task automatic t_reset();
    `CHK("mode", 3'h0, modeStatus)
    `CHK("linked", 1'b1, wakeInputsLinked)
    `CHK("idle drive", 1'b0, serialOutEn)
    rd(`SBSM_ADDR_SWITCH_CONTROL, `SBSM_SWITCH_RESET, "switch reset");
    $display("t_reset done");
  endtask
  task automatic t_mode();
    logic [3:0] m [4] = '{4'h2, 4'h4, 4'h7, 4'h1};
    wr(`SBSM_ADDR_MODE_CONTROL, 4'h1);
    `CHK("mode single", 3'h0, modeStatus)
    rd(`SBSM_ADDR_MODE_CONTROL, 4'h0, "mode read");
    foreach (m[i])
    begin
      wr(`SBSM_ADDR_MODE_CONTROL, m[i]);
      wr(`SBSM_ADDR_MODE_VALIDATION, m[i]);
      `CHK("mode pair", m[i][2:0], modeStatus)
    end
    wr(`SBSM_ADDR_MODE_CONTROL, 4'h2);
    wr(`SBSM_ADDR_MODE_VALIDATION, 4'h4);
    `CHK("mode mismatch", 3'h1, modeStatus)
    rd(`SBSM_ADDR_MODE_VALIDATION, 4'h1, "valid read");
    $display("t_mode done");
  endtask
  task automatic t_bad();
    sbsm_frame_t b [3];
    int c;
    b = '{fr(6'h03, 2'h3, 4'h2) ^ 16'h0010, fr(6'h01, 2'h3, 4'h2), fr(6'h03, 2'h1, 4'h2)};
    wr(`SBSM_ADDR_MODE_CONTROL, 4'h2);
    foreach (b[i])
    begin
      c = irqCnt;
      go(b[i], 1'b0);
      `CHK("irq count", c + 1, irqCnt)
      `CHK("mode kept", 3'h1, modeStatus)
    end
    rd(`SBSM_ADDR_ERROR_FLAG, 4'h1, "error flag");
    rd(`SBSM_ADDR_ERROR_FLAG, 4'h0, "flag cleared");
    $display("t_bad done");
  endtask
  task automatic t_switch();
    int c;
    wr(`SBSM_ADDR_SWITCH_CONTROL, 4'h1);
    `CHK("switch on", 1'b1, highSideSwitchOn)
    wr(`SBSM_ADDR_SWITCH_CONTROL, 4'h3);
    `CHK("cyclic gate", 2'b01, {highSideSwitchOn, cyclicSenseOn})
    wr(`SBSM_ADDR_SWITCH_CONTROL, 4'h5);
    `CHK("forced gate", 3'b010, {highSideSwitchOn, forcedWakeOn, wakeInputsLinked})
    c = irqCnt;
    go(fr(`SBSM_ADDR_SWITCH_CONTROL, `SBSM_RW_WRITE, 4'h1), 1'b0, 15);
    `CHK("short frame", {c, 1'b1}, {irqCnt, forcedWakeOn})
    $display("t_switch done");
  endtask
  task automatic t_pin();
    @(posedge clk);
    #1 resetInN = 1'b0;
    repeat (8) @(posedge clk);
    `CHK("pin reset", 3'b101, {modeStatus == 3'h0, forcedWakeOn, wakeInputsLinked})
    #1 resetInN = 1'b1;
    $display("t_pin done");
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    resetInN = 1'b1;
    prv = '0;
    hdr = '0;
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_mode();
    t_bad();
    t_switch();
    t_pin();
    end_of_test();
  end
endmodule
`default_nettype wire
